// File: hdl/acr_pkg.sv
// constants, carrier types and helpers for the conversion and read-out block
// assumes a 200 MHz system clock and a host-driven serial clock
package acr_pkg;

  // ==========================================================
  // result word and bit counting
  localparam int RES_W = 16;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] BITS_PLAIN = 5'h10;
  localparam logic [CNT_W-1:0] BITS_BUSY = 5'h11;
  localparam logic [CNT_W-1:0] CNT_CAP = 5'h11;

  // ==========================================================
  // timing
  localparam int CLK_MHZ = 200;
  localparam int T_CONV_MIN_NS = 500;
  localparam int T_CONV_MAX_NS = 880;
  localparam int CONV_MIN_CYC = (T_CONV_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int CONV_MAX_CYC = (T_CONV_MAX_NS * CLK_MHZ) / 1000;

  // ==========================================================
  // reset values and LFSR taps
  localparam logic [15:0] LFSR_SEED = 16'hace1;
  localparam logic [15:0] LFSR_TAPS = 16'hb400;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [RES_W-1:0] WORD_ZERO = 16'h0000;

  // ==========================================================
  // types
  typedef enum logic {ACR_ACQ, ACR_CONV} acr_phase_t;

  typedef struct packed {
    logic trigger;
    logic din;
  } acr_ctl_t;

  typedef struct packed {
    logic converting;
    logic powered_down;
    logic cs_mode;
    logic busy_en;
    logic result_valid;
  } acr_status_t;

  // ==========================================================
  // gray helpers
  function automatic logic [CNT_W-1:0] acr_bin2gray(
    input logic [CNT_W-1:0] b
  );
    acr_bin2gray = b ^ (b >> 1);
  endfunction : acr_bin2gray

  function automatic logic [CNT_W-1:0] acr_gray2bin(
    input logic [CNT_W-1:0] g
  );
    logic [CNT_W-1:0] b;
    b = '0;
    for (int i = CNT_W - 1; i >= 0; i--)
    begin
      b[i] = (i == CNT_W - 1) ? g[i] : (b[i+1] ^ g[i]);
    end
    acr_gray2bin = b;
  endfunction : acr_gray2bin

endpackage : acr_pkg

// File: hdl/acr_sync.sv
// two-flop synchroniser for a group of level signals
// assumes each bit is a level or a gray-coded word stepping one bit at a time
`timescale 1ns/1ps
module acr_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // signals
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  import acr_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } acr_sync_st_t;

  acr_sync_st_t st_q;
  acr_sync_st_t st_d;

  initial
  begin
    if (WIDTH < 1)
      $error("acr_sync: WIDTH must be at least 1");
  end

  always_comb
  begin
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign q = st_q.s2;

endmodule : acr_sync

// File: hdl/acr_edge_count.sv
// link-side counter of serial clock falling edges within one read frame
// assumes the frame is idle while frame_idle is high; that level clears it
`timescale 1ns/1ps
module acr_edge_count (
  // link clock and frame
  input wire logic serial_clock,
  input wire logic frame_idle,
  // gray-coded edge count
  output logic [acr_pkg::CNT_W-1:0] count_gray
);
  import acr_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] gray;
  } acr_link_st_t;

  acr_link_st_t st_q;
  acr_link_st_t st_d;
  logic [CNT_W-1:0] bin;

  always_comb
  begin
    st_d = st_q;
    bin = acr_gray2bin(st_q.gray);
    // saturate so the word never wraps back to the first bit
    if (bin != CNT_CAP)
      st_d.gray = acr_bin2gray(bin + 5'h01);
  end

  // the clock stands still between frames; the frame's own level clears it
  always_ff @(negedge serial_clock or posedge frame_idle)
  begin
    if (frame_idle)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign count_gray = st_q.gray;

endmodule : acr_edge_count

// File: hdl/acr_core.sv
// conversion control and serial read-out of a 16-bit converter
// assumes sample_code is the two's complement difference from the sampler,
// the host drives conversion_trigger, serial_in and serial_clock
`timescale 1ns/1ps

// Notes on behaviour
// (R1) trigger rising edge samples serial input; high picks chip-select mode; here it must also be high one cycle before the edge
// (R2) serial input low at trigger rise selects daisy-chain mode
// (R3) with busy indicator enabled, one indicator bit precedes the result
// (R4) trigger rise tri-states output, captures sample, starts conversion
// (R5) conversion runs to the end regardless of trigger level
// (R6) conversion length varies but stays within minimum and maximum
// (R7) host restores trigger high before minimum, holds until maximum time
// (R8) trigger high at conversion end means no busy indicator bit
// (R9) conversion end enters powered-down acquisition until next trigger rise
// (R10) trigger falls after maximum time; output drives and shows MSB
// (R11) each following serial clock falling edge presents the next lower bit
// (R12) host may capture on either serial clock edge
// (R13) output tri-states after sixteenth falling edge or on trigger rise
// (R14) result word is two's complement
// (R15) serial clock only reads results, during acquisition after conversion
// (R16) trigger is chip select in 3-wire, serial input in 4-wire; only the 3-wire read is served, serial input never acts as chip select
// (R17) host counts sixteen falling edges MSB first, drops partial words
module acr_core #(
  parameter int CONV_MIN = acr_pkg::CONV_MIN_CYC,
  parameter int CONV_MAX = acr_pkg::CONV_MAX_CYC
) (
  // system clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // host pins
  input wire logic conversion_trigger,
  input wire logic serial_in,
  input wire logic serial_clock,
  // sampled input word
  input wire logic [acr_pkg::RES_W-1:0] sample_code,
  // serial output pin
  output logic serial_out,
  output logic serial_out_oe,
  // status
  output acr_pkg::acr_status_t status
);
  import acr_pkg::*;

  // ==========================================================
  // parameter checks
  localparam int SPAN = CONV_MAX - CONV_MIN + 1;

  initial
  begin
    if (CONV_MIN < 1)
      $error("acr_core: CONV_MIN must be at least one cycle");
    if (CONV_MAX < CONV_MIN)
      $error("acr_core: CONV_MAX below CONV_MIN");
    if (CONV_MAX > 65535)
      $error("acr_core: CONV_MAX exceeds the cycle counter");
  end

  // ==========================================================
  // state
  typedef struct packed {
    acr_phase_t phase;
    logic trig_prev;
    // mode line one cycle before the trigger edge; a tied mode line reads low
    logic din_prev;
    logic [15:0] conv_cnt;
    logic [15:0] conv_len;
    logic [15:0] lfsr;
    logic [RES_W-1:0] sample;
    logic [RES_W-1:0] word;
    logic cs_mode;
    logic busy_en;
    logic powered_down;
    logic result_valid;
    logic sdo;
    logic sdo_oe;
  } acr_core_st_t;

  acr_core_st_t st_q;
  acr_core_st_t st_d;

  // ==========================================================
  // pin synchronisers and link counter
  acr_ctl_t ctl_pin;
  acr_ctl_t ctl_s;
  logic [CNT_W-1:0] count_gray;
  logic [CNT_W-1:0] count_gray_s;

  assign ctl_pin.trigger = conversion_trigger;
  assign ctl_pin.din = serial_in;

  acr_sync #(
    .WIDTH(2)
  ) u_ctl_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .d(ctl_pin),
    .q(ctl_s)
  );

  // trigger high ends the frame and clears the edge count (see R13)
  acr_edge_count u_edge_count (
    .serial_clock(serial_clock),
    .frame_idle(conversion_trigger),
    .count_gray(count_gray)
  );

  acr_sync #(
    .WIDTH(CNT_W)
  ) u_cnt_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .d(count_gray),
    .q(count_gray_s)
  );

  // ==========================================================
  // helpers
  function automatic logic [15:0] acr_pick_len(
    input logic [15:0] rnd
  );
    int v;
    v = CONV_MIN + (int'(rnd) % SPAN);
    acr_pick_len = v[15:0];
  endfunction : acr_pick_len

  function automatic logic [15:0] acr_lfsr_step(
    input logic [15:0] r
  );
    acr_lfsr_step = r[0] ? ((r >> 1) ^ LFSR_TAPS) : (r >> 1);
  endfunction : acr_lfsr_step

  // ==========================================================
  // next-state logic
  logic trig_rise;
  logic [CNT_W-1:0] edges;
  logic [CNT_W-1:0] limit;
  logic [CNT_W-1:0] pos;

  always_comb
  begin
    st_d = st_q;
    trig_rise = ctl_s.trigger & ~st_q.trig_prev;
    edges = acr_gray2bin(count_gray_s);
    limit = st_q.busy_en ? BITS_BUSY : BITS_PLAIN;
    pos = '0;
    st_d.trig_prev = ctl_s.trigger;
    st_d.din_prev = ctl_s.din;
    // keep the length source moving so lengths differ per conversion
    st_d.lfsr = acr_lfsr_step(st_q.lfsr); // see R6

    unique case (st_q.phase)
      ACR_ACQ:
      begin
        if (trig_rise)
        begin
          // mode line must be high before and at the edge, so a line tied
          // to the trigger rises with it and still picks daisy-chain
          st_d.cs_mode = ctl_s.din & st_q.din_prev; // see R1 see R2
          // a low serial input picks daisy-chain, which is not read here
          st_d.phase = ACR_CONV; // see R2
          // the old result is gone once a new sample is taken
          st_d.result_valid = 1'b0;
          st_d.busy_en = 1'b0;
          st_d.sample = sample_code; // see R4
          st_d.sdo_oe = 1'b0; // see R4
          st_d.sdo = 1'b0;
          st_d.powered_down = 1'b0;
          st_d.conv_cnt = CNT_ZERO;
          st_d.conv_len = acr_pick_len(st_q.lfsr); // see R6
        end
        else if (!st_q.cs_mode || !st_q.result_valid)
        begin
          // nothing to read: daisy-chain is not served, no result yet
          st_d.sdo_oe = 1'b0; // see R15
        end
        else if (ctl_s.trigger)
        begin
          st_d.sdo_oe = 1'b0; // see R13
        end
        else if (edges >= limit)
        begin
          st_d.sdo_oe = 1'b0; // see R13
        end
        else
        begin
          // trigger low acts as chip select in the 3-wire read
          st_d.sdo_oe = 1'b1; // see R16
          if (st_q.busy_en && edges == 5'h00)
          begin
            st_d.sdo = 1'b0; // see R3
          end
          else
          begin
            // busy bit shifts the data one edge later
            pos = st_q.busy_en ? (edges - 5'h01) : edges;
            // MSB at the trigger fall, then one lower per falling edge
            st_d.sdo = st_q.word[4'hf - pos[3:0]]; // see R10 see R11 see R14
          end
        end
      end

      ACR_CONV:
      begin
        // trigger level is ignored until the count runs out
        st_d.sdo_oe = 1'b0;
        if (st_q.conv_cnt == st_q.conv_len - 16'h0001)
        begin
          st_d.phase = ACR_ACQ; // see R5
          st_d.word = st_q.sample; // see R14
          st_d.busy_en = st_q.cs_mode & ~ctl_s.trigger; // see R8
          st_d.powered_down = 1'b1; // see R9
          st_d.result_valid = 1'b1; // see R15
        end
        else
        begin
          st_d.conv_cnt = st_q.conv_cnt + 16'h0001; // see R5
        end
      end
    endcase
  end

  // ==========================================================
  // state register
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      st_q.phase <= ACR_ACQ;
      st_q.trig_prev <= 1'b0;
      st_q.din_prev <= 1'b0;
      st_q.conv_cnt <= CNT_ZERO;
      st_q.conv_len <= CNT_ZERO;
      st_q.lfsr <= LFSR_SEED;
      st_q.sample <= WORD_ZERO;
      st_q.word <= WORD_ZERO;
      st_q.cs_mode <= 1'b0;
      st_q.busy_en <= 1'b0;
      st_q.powered_down <= 1'b1;
      st_q.result_valid <= 1'b0;
      st_q.sdo <= 1'b0;
      st_q.sdo_oe <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // outputs
  assign serial_out = st_q.sdo;
  assign serial_out_oe = st_q.sdo_oe;
  assign status.converting = (st_q.phase == ACR_CONV);
  assign status.powered_down = st_q.powered_down;
  assign status.cs_mode = st_q.cs_mode;
  assign status.busy_en = st_q.busy_en;
  assign status.result_valid = st_q.result_valid;

endmodule : acr_core

// File: verification/acr_core_checker.sv
// assertions on the pins and status of the conversion and read-out block
// assumes it is bound into acr_core and sees only its ports
`timescale 1ns/1ps
module acr_core_checker #(
  parameter int CONV_MIN = 12,
  parameter int CONV_MAX = 20
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // pins and status
  input wire logic conversion_trigger,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire acr_pkg::acr_status_t status
);
  import acr_pkg::*;
  typedef struct packed {
    logic [7:0] len;
  } acr_chk_t;
  acr_chk_t chk_q;
  acr_chk_t chk_d;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // length of the converting phase
  always_comb
  begin
    chk_d.len = status.converting ? chk_q.len + 8'h01 : 8'h00;
  end
  always_ff @(posedge clock)
  begin
    chk_q <= chk_d;
  end
  // ==========================================================
  // properties
  a_len_bound: assert property ($fell(status.converting) |->
    chk_q.len >= CONV_MIN && chk_q.len <= CONV_MAX)
    else $error("conversion length out of bounds");
  a_conv_quiet: assert property (status.converting |->
    !serial_out_oe && !status.powered_down && !status.result_valid)
    else $error("output or acquisition state during conversion");
  a_acq_enter: assert property ($fell(status.converting) |->
    status.powered_down && status.result_valid)
    else $error("conversion end without acquisition");
  a_daisy_silent: assert property (!status.cs_mode |->
    !serial_out_oe)
    else $error("output driven outside chip-select mode");
  a_trig_release: assert property ($rose(conversion_trigger) |->
    ##[0:4] !serial_out_oe)
    else $error("output not released after trigger rise");
  a_oe_cause: assert property ($rose(serial_out_oe) |->
    !conversion_trigger && status.result_valid)
    else $error("output driven without select");
  a_busy_bit: assert property ($rose(serial_out_oe) && status.busy_en
    |-> !serial_out)
    else $error("busy indicator bit not low");
  a_no_busy: assert property (status.busy_en |->
    status.cs_mode && status.result_valid)
    else $error("busy indicator outside chip-select result");
  a_read_acq: assert property (serial_out_oe |->
    status.powered_down && !status.converting)
    else $error("read outside acquisition");
endmodule : acr_core_checker

bind acr_core acr_core_checker #(
  .CONV_MIN(CONV_MIN),
  .CONV_MAX(CONV_MAX)
) acr_core_checker_i (
  .clock(clock),
  .sys_rst(sys_rst),
  .conversion_trigger(conversion_trigger),
  .serial_out(serial_out),
  .serial_out_oe(serial_out_oe),
  .status(status)
);

// File: verification/acr_host.sv
// host model: trigger, mode line and a 32 ns serial clock in frames only
// assumes bits are taken just before the next falling edge
`timescale 1ns/1ps
module acr_host (
  // host pins
  output logic conversion_trigger,
  output logic serial_in,
  output logic serial_clock,
  // device pin
  input wire logic serial_out,
  input wire logic serial_out_oe
);
  initial
  begin
    conversion_trigger = 1'b0;
    serial_in = 1'b1;
    serial_clock = 1'b1;
  end
  // trigger doubles as chip select, serial_in picks the mode
  task automatic drive(input logic trig, input logic din);
    conversion_trigger = trig;
    serial_in = din;
  endtask : drive
  // a released line reads as the inverse of the last bit
  task automatic read(input int n, output logic [15:0] w);
    w = 16'h0000;
    repeat (n)
    begin
      w = {w[14:0], serial_out_oe ? serial_out : ~w[0]};
      serial_clock = 1'b0;
      #16;
      serial_clock = 1'b1;
      #16;
    end
  endtask : read
endmodule : acr_host

// File: verification/tb.sv
// self-checking bench for acr_core with the host model on its pins
// assumes shortened conversion bounds of 12 to 20 cycles
`timescale 1ns/1ps
module tb;
  import acr_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [RES_W-1:0] sample_code = 16'h0000;
  logic conversion_trigger, serial_in, serial_clock;
  logic serial_out, serial_out_oe;
  acr_status_t status;
  int miscompares = 0;
  int total_checks = 0;
  always #2.5 clock = ~clock;
  acr_core #(.CONV_MIN(12), .CONV_MAX(20)) acr_core_i (
    .clock(clock),
    .sys_rst(sys_rst),
    .conversion_trigger(conversion_trigger),
    .serial_in(serial_in),
    .serial_clock(serial_clock),
    .sample_code(sample_code),
    .serial_out(serial_out),
    .serial_out_oe(serial_out_oe),
    .status(status)
  );
  acr_host acr_host_i (
    .conversion_trigger(conversion_trigger),
    .serial_in(serial_in),
    .serial_clock(serial_clock),
    .serial_out(serial_out),
    .serial_out_oe(serial_out_oe)
  );
  task automatic conclude();
    if (miscompares == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_conv(input logic v);
    int n;
    n = 0;
    while (status.converting !== v && n < 60)
    begin
      @(negedge clock);
      n++;
    end
    chk({15'h0000, status.converting}, {15'h0000, v});
  endtask : wait_conv
  // start a conversion; low keeps the trigger low to its end
  task automatic conv(input logic din, input logic low);
    @(negedge clock);
    acr_host_i.drive(1'b0, din);
    repeat (4) @(negedge clock);
    acr_host_i.drive(1'b1, din);
    wait_conv(1'b1);
    acr_host_i.drive(1'b0, low | din);
    if (!low)
    begin
      repeat (2) @(negedge clock);
      acr_host_i.drive(1'b1, din);
    end
    wait_conv(1'b0);
  endtask : conv
  task automatic t_read(input logic [15:0] code);
    logic [15:0] w;
    sample_code = code;
    conv(1'b1, 1'b0);
    chk({11'h000, status}, 16'h000d);
    repeat (20) @(negedge clock);
    acr_host_i.drive(1'b0, 1'b1);
    repeat (4) @(negedge clock);
    chk({15'h0000, serial_out_oe}, 16'h0001);
    acr_host_i.read(16, w);
    chk(w, code);
    @(negedge clock);
    repeat (6) @(negedge clock);
    chk({15'h0000, serial_out_oe}, 16'h0000);
  endtask : t_read
  task automatic t_partial(input logic [15:0] code);
    logic [15:0] w;
    sample_code = code;
    conv(1'b1, 1'b0);
    repeat (20) @(negedge clock);
    acr_host_i.drive(1'b0, 1'b1);
    repeat (4) @(negedge clock);
    acr_host_i.read(5, w);
    chk(w, {11'h000, code[15:11]});
    @(negedge clock);
    acr_host_i.drive(1'b1, 1'b1);
    repeat (5) @(negedge clock);
    chk({15'h0000, serial_out_oe}, 16'h0000);
    wait_conv(1'b0);
  endtask : t_partial
  task automatic t_daisy();
    conv(1'b0, 1'b0);
    chk({15'h0000, status.cs_mode}, 16'h0000);
    acr_host_i.drive(1'b0, 1'b0);
    repeat (8) @(negedge clock);
    chk({15'h0000, serial_out_oe}, 16'h0000);
    // mode line tied to the trigger: both rise together
    repeat (4) @(negedge clock);
    acr_host_i.drive(1'b1, 1'b1);
    wait_conv(1'b1);
    wait_conv(1'b0);
    chk({15'h0000, status.cs_mode}, 16'h0000);
  endtask : t_daisy
  task automatic t_busy();
    logic [15:0] w;
    sample_code = 16'hffff;
    conv(1'b1, 1'b1);
    repeat (2) @(negedge clock);
    chk({14'h0000, status.busy_en, serial_out_oe}, 16'h0003);
    chk({15'h0000, serial_out}, 16'h0000);
    acr_host_i.read(16, w);
    chk(w, 16'h7fff);
  endtask : t_busy
  initial
  begin
    #60000;
    miscompares++;
    conclude();
  end
  initial
  begin
    repeat (8) @(negedge clock);
    chk({11'h000, status}, 16'h0008);
    chk({15'h0000, serial_out_oe}, 16'h0000);
    sys_rst = 1'b0;
    repeat (2) @(negedge clock);
    t_read(16'h8001);
    t_read(16'h7ffe);
    t_partial(16'ha5c3);
    t_daisy();
    t_busy();
    conclude();
  end
endmodule : tb
